//--- tsr_register_set.v
`timescale 1ns/1ns
`include "tsr_defines.vh"

module tsr_register_set (
  input wire clk,
  input wire reset_n,
  input wire sclIn,
  input wire sdaIn,
  output wire sdaOut,
  output reg sdaOe,
  input wire [2:0] addrSel,
  output wire alertOut,
  output reg alertOe,
  output reg convStart,
  output reg convAbort,
  input wire convDone,
  input wire [11:0] convResult
);
  // ==========================================================
  // bus states
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_AACK = 3'h2;
  localparam ST_RX = 3'h3;
  localparam ST_RACK = 3'h4;
  localparam ST_TX = 3'h5;
  localparam ST_TACK = 3'h6;
  localparam ST_WAIT = 3'h7;

  reg [2:0] state_q;
  reg [3:0] bitCnt_q;
  reg [7:0] rxShift_q;
  reg [7:0] txShift_q;
  reg rw_q;
  reg txSel_q;
  reg [1:0] byteIdx_q;
  reg [7:0] msbHold_q;
  reg [15:0] readWord_q;
  reg readEvt_q;
  reg oneShotEvt_q;
  reg [2:0] ptr_q;
  reg os_q;
  reg [1:0] fq_q;
  reg pol_q;
  reg tm_q;
  reg sd_q;
  reg [11:0] hiLim_q;
  reg [11:0] loLim_q;
  reg [11:0] temp_q;
  reg busy_q;
  reg pending_q;
  reg [2:0] hiCnt_q;
  reg [2:0] loCnt_q;
  reg active_q;
  reg armHigh_q;
  reg sclPrev_q;
  reg sdaPrev_q;
  reg [15:0] rdData;
  reg [2:0] depth;
  reg [2:0] hiNext;
  reg [2:0] loNext;
  wire [1:0] busF;
  wire [2:0] addrF;
  wire sclF;
  wire sdaF;
  wire sclRise;
  wire sclFall;
  wire startCond;
  wire stopCond;
  wire [15:0] wrWord;
  wire [7:0] nextByte;
  wire resultEvt;
  wire faultHi;
  wire faultLo;

  // ==========================================================
  // pin synchronisers
  tsr_pin_sync #(.W(2), .RST_VAL(2'h3)) uBusSync (
    .clk(clk),
    .reset_n(reset_n),
    .pinIn({sclIn, sdaIn}),
    .pinOut(busF)
  );

  // straps pass the same filter, so a bouncing strap cannot flicker the address
  tsr_pin_sync #(.W(3), .RST_VAL(3'h0)) uAddrSync (
    .clk(clk),
    .reset_n(reset_n),
    .pinIn(addrSel),
    .pinOut(addrF)
  );

  // bus line events
  assign sclF = busF[1];
  assign sdaF = busF[0];
  assign sclRise = sclF & ~sclPrev_q;
  assign sclFall = ~sclF & sclPrev_q;
  assign startCond = sclF & sclPrev_q & sdaPrev_q & ~sdaF;
  assign stopCond = sclF & sclPrev_q & ~sdaPrev_q & sdaF;

  // open drain: the pin is only ever pulled low
  assign sdaOut = 1'b0;
  assign alertOut = 1'b0;

  // write word pairs the held upper byte with the lower byte just received
  assign wrWord = {msbHold_q, rxShift_q};
  assign nextByte = txSel_q ? readWord_q[7:0] : readWord_q[15:8];

  // ==========================================================
  // register read mux
  always @* begin
    case (ptr_q)
      `TSR_PTR_TEMP: rdData = {temp_q, `TSR_RSVD_LOW};
      `TSR_PTR_CONF: rdData = {2'h0, os_q, fq_q, pol_q, tm_q, sd_q, 8'h00};
      `TSR_PTR_HIGH: rdData = {hiLim_q, `TSR_RSVD_LOW};
      `TSR_PTR_LOW: rdData = {loLim_q, `TSR_RSVD_LOW};
      default: rdData = 16'h0000; // one-shot register is write only
    endcase
  end

  // ==========================================================
  // two-wire slave and register writes
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      rxShift_q <= 8'h00;
      txShift_q <= 8'h00;
      rw_q <= 1'b0;
      txSel_q <= 1'b0;
      byteIdx_q <= 2'h0;
      msbHold_q <= 8'h00;
      readWord_q <= 16'h0000;
      readEvt_q <= 1'b0;
      oneShotEvt_q <= 1'b0;
      sdaOe <= 1'b0;
      ptr_q <= `TSR_PTR_RST;
      // configuration fields all reset to zero
      os_q <= 1'b0;
      fq_q <= 2'h0;
      pol_q <= 1'b0;
      tm_q <= 1'b0;
      sd_q <= 1'b0;
      hiLim_q <= 12'h500; // reset code of high limit bits 15..4
      loLim_q <= 12'h4b0; // reset code of low limit bits 15..4
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclF;
      sdaPrev_q <= sdaF;
      readEvt_q <= 1'b0;
      oneShotEvt_q <= 1'b0;
      if (startCond) begin
        state_q <= ST_ADDR;
        bitCnt_q <= 4'h0;
        sdaOe <= 1'b0;
      end else if (stopCond) begin
        state_q <= ST_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR: begin
            if (sclRise) begin
              rxShift_q <= {rxShift_q[6:0], sdaF};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == `TSR_BITS_PER_BYTE) begin
              if (rxShift_q[7:1] == {`TSR_ADDR_BASE, addrF}) begin
                state_q <= ST_AACK;
                sdaOe <= 1'b1;
                rw_q <= rxShift_q[0];
                byteIdx_q <= 2'h0;
                // snapshot keeps both bytes of one word coherent
                readWord_q <= rdData;
                txSel_q <= 1'b0;
                readEvt_q <= rxShift_q[0];
              end else begin
                state_q <= ST_WAIT;
              end
            end
          end
          ST_AACK: begin
            if (sclFall) begin
              bitCnt_q <= 4'h0;
              if (rw_q) begin
                state_q <= ST_TX;
                txShift_q <= readWord_q[15:8];
                sdaOe <= ~readWord_q[15];
                txSel_q <= 1'b1;
              end else begin
                state_q <= ST_RX;
                sdaOe <= 1'b0;
              end
            end
          end
          ST_RX: begin
            if (sclRise) begin
              rxShift_q <= {rxShift_q[6:0], sdaF};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == `TSR_BITS_PER_BYTE) begin
              state_q <= ST_RACK;
              sdaOe <= 1'b1;
              if (byteIdx_q == 2'h0) begin
                ptr_q <= rxShift_q[2:0];
                byteIdx_q <= 2'h1;
              end else if (byteIdx_q == 2'h1) begin
                msbHold_q <= rxShift_q;
                byteIdx_q <= 2'h2;
                oneShotEvt_q <= (ptr_q == `TSR_PTR_ONESHOT);
              end else begin
                byteIdx_q <= 2'h1;
                case (ptr_q)
                  `TSR_PTR_CONF: begin
                    os_q <= wrWord[`TSR_CFG_OS_BIT];
                    fq_q <= wrWord[`TSR_CFG_FQ_HI:`TSR_CFG_FQ_LO];
                    pol_q <= wrWord[`TSR_CFG_POL_BIT];
                    tm_q <= wrWord[`TSR_CFG_TM_BIT];
                    sd_q <= wrWord[`TSR_CFG_SD_BIT];
                  end
                  `TSR_PTR_HIGH: hiLim_q <= wrWord[`TSR_VAL_HI:`TSR_VAL_LO];
                  `TSR_PTR_LOW: loLim_q <= wrWord[`TSR_VAL_HI:`TSR_VAL_LO];
                  default: begin
                    // temperature is read only, one-shot acts on its first byte
                  end
                endcase
              end
            end
          end
          ST_RACK: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              state_q <= ST_RX;
              bitCnt_q <= 4'h0;
            end
          end
          ST_TX: begin
            if (sclRise) begin
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall) begin
              if (bitCnt_q == `TSR_BITS_PER_BYTE) begin
                state_q <= ST_TACK;
                sdaOe <= 1'b0;
              end else begin
                txShift_q <= {txShift_q[6:0], 1'b0};
                sdaOe <= ~txShift_q[6];
              end
            end
          end
          ST_TACK: begin
            if (sclRise && sdaF) begin
              state_q <= ST_WAIT; // master refused, stop sending
            end else if (sclFall) begin
              state_q <= ST_TX;
              bitCnt_q <= 4'h0;
              txShift_q <= nextByte;
              sdaOe <= ~nextByte[7];
              txSel_q <= ~txSel_q;
            end
          end
          default: begin
            // idle or not addressed: wait for start or stop
          end
        endcase
      end
    end
  end

  // ==========================================================
  // conversion control
  assign resultEvt = busy_q & convDone & ~sd_q;

  // pending is cleared first so a same-cycle one-shot write is not lost
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      pending_q <= 1'b0;
      convStart <= 1'b0;
      convAbort <= 1'b0;
      temp_q <= 12'h000;
    end else begin
      convStart <= 1'b0;
      convAbort <= 1'b0;
      if (sd_q) begin
        busy_q <= 1'b0;
        pending_q <= 1'b0;
        convAbort <= busy_q;
      end else begin
        if (resultEvt) begin
          temp_q <= convResult;
          busy_q <= 1'b0;
        end else if (!busy_q && (!os_q || pending_q)) begin
          convStart <= 1'b1;
          busy_q <= 1'b1;
          pending_q <= 1'b0;
        end
        if (oneShotEvt_q && os_q) begin
          pending_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // fault queue decode and counting
  assign faultHi = $signed(convResult) > $signed(hiLim_q);
  assign faultLo = $signed(convResult) < $signed(loLim_q);

  always @* begin
    case (fq_q)
      2'h0: depth = `TSR_FQ_DEPTH0;
      2'h1: depth = `TSR_FQ_DEPTH1;
      2'h2: depth = `TSR_FQ_DEPTH2;
      default: depth = `TSR_FQ_DEPTH3;
    endcase
    hiNext = 3'h0;
    loNext = 3'h0;
    // counters saturate so a long run never wraps below the depth
    if (faultHi) begin
      hiNext = (hiCnt_q == `TSR_FAULT_MAX) ? hiCnt_q : hiCnt_q + 3'h1;
    end else if (faultLo) begin
      loNext = (loCnt_q == `TSR_FAULT_MAX) ? loCnt_q : loCnt_q + 3'h1;
    end
  end

  // ==========================================================
  // alarm state
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hiCnt_q <= 3'h0;
      loCnt_q <= 3'h0;
      active_q <= 1'b0;
      armHigh_q <= 1'b1;
      alertOe <= 1'b0;
    end else begin
      // polarity bit zero: active alarm pulls the pin low
      alertOe <= ~(pol_q ? active_q : ~active_q);
      if (sd_q) begin
        hiCnt_q <= 3'h0;
        loCnt_q <= 3'h0;
        active_q <= 1'b0;
        armHigh_q <= 1'b1;
      end else if (!tm_q) begin
        armHigh_q <= 1'b1;
        if (resultEvt) begin
          hiCnt_q <= hiNext;
          loCnt_q <= loNext;
          if (hiNext >= depth) begin
            active_q <= 1'b1;
          end else if (loNext >= depth) begin
            active_q <= 1'b0;
          end
        end
      end else begin
        // read clears first, so a new trigger in the same cycle wins
        if (readEvt_q) begin
          active_q <= 1'b0;
        end
        if (resultEvt) begin
          hiCnt_q <= hiNext;
          loCnt_q <= loNext;
          if (armHigh_q && hiNext >= depth) begin
            active_q <= 1'b1;
            armHigh_q <= 1'b0;
            hiCnt_q <= 3'h0;
            loCnt_q <= 3'h0;
          end else if (!armHigh_q && loNext >= depth) begin
            active_q <= 1'b1;
            armHigh_q <= 1'b1;
            hiCnt_q <= 3'h0;
            loCnt_q <= 3'h0;
          end
        end
      end
    end
  end
endmodule // tsr_register_set

//--- tsr_defines.vh
`ifndef TSR_DEFINES_VH
`define TSR_DEFINES_VH

// ==========================================================
// pointer values (low three pointer bits only)
`define TSR_PTR_TEMP 3'h0
`define TSR_PTR_CONF 3'h1
`define TSR_PTR_HIGH 3'h2
`define TSR_PTR_LOW 3'h3
`define TSR_PTR_ONESHOT 3'h4
`define TSR_PTR_RST 3'h0

// ==========================================================
// reset values
`define TSR_TEMP_RST 16'h0000
`define TSR_CONF_RST 16'h0000
`define TSR_HIGH_RST 16'h5000
`define TSR_LOW_RST 16'h4b00

// ==========================================================
// configuration field positions
`define TSR_CFG_OS_BIT 13
`define TSR_CFG_FQ_HI 12
`define TSR_CFG_FQ_LO 11
`define TSR_CFG_POL_BIT 10
`define TSR_CFG_TM_BIT 9
`define TSR_CFG_SD_BIT 8

// ==========================================================
// limit and result field positions
`define TSR_VAL_HI 15
`define TSR_VAL_LO 4
`define TSR_RSVD_LOW 4'h0

// ==========================================================
// fault queue depths per code
`define TSR_FQ_DEPTH0 3'h1
`define TSR_FQ_DEPTH1 3'h2
`define TSR_FQ_DEPTH2 3'h4
`define TSR_FQ_DEPTH3 3'h6
`define TSR_FAULT_MAX 3'h7

// ==========================================================
// two-wire bus constants
`define TSR_ADDR_BASE 4'h9
`define TSR_BITS_PER_BYTE 4'h8

`endif

//--- tsr_pin_sync.v
`timescale 1ns/1ns

// ==========================================================
// three-stage pin synchroniser with agreement filter
module tsr_pin_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire clk,
  input wire reset_n,
  input wire [W-1:0] pinIn,
  output reg [W-1:0] pinOut
);
  reg [W-1:0] stage1_q;
  reg [W-1:0] stage2_q;
  reg [W-1:0] stage3_q;
  integer i;

  // stage1 only feeds stage2; output moves once stages 2 and 3 agree
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= RST_VAL;
      stage2_q <= RST_VAL;
      stage3_q <= RST_VAL;
      pinOut <= RST_VAL;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      for (i = 0; i < W; i = i + 1) begin
        if (stage2_q[i] == stage3_q[i]) begin
          pinOut[i] <= stage3_q[i];
        end
      end
    end
  end
endmodule // tsr_pin_sync

//--- tsr_register_set_asserts.sv
`timescale 1ns/1ns
// ======
// port checks
module tsr_register_set_asserts (
  input wire clk,
  input wire reset_n,
  input wire sclIn,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOe,
  input wire [2:0] addrSel,
  input wire alertOut,
  input wire alertOe,
  input wire convStart,
  input wire convAbort,
  input wire convDone,
  input wire [11:0] convResult
);
  reg busyQ;
  reg [3:0] lowAgeQ;
  // converter busy span and age of the last scl low sample
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busyQ <= 1'b0;
      lowAgeQ <= 4'hf;
    end else begin
      if (convStart)
        busyQ <= 1'b1;
      else if (convDone || convAbort)
        busyQ <= 1'b0;
      if (!sclIn)
        lowAgeQ <= 4'h0;
      else if (lowAgeQ != 4'hf)
        lowAgeQ <= lowAgeQ + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // scl high long enough for the synchroniser to have seen it
  sequence sclSettled;
    sclIn [*4];
  endsequence
  sda_value_zero_a: assert property (sdaOut == 1'b0)
    else $error("sda value not zero");
  alert_value_zero_a: assert property (alertOut == 1'b0)
    else $error("alert value not zero");
  start_one_cycle_a: assert property (convStart |=> !convStart)
    else $error("start pulse too long");
  abort_one_cycle_a: assert property (convAbort |=> !convAbort)
    else $error("abort pulse too long");
  start_when_idle_a: assert property (convStart |-> !busyQ)
    else $error("start while busy");
  abort_when_busy_a: assert property (convAbort |-> busyQ)
    else $error("abort while idle");
  start_abort_apart_a: assert property (!(convStart && convAbort))
    else $error("start with abort");
  sda_high_stable_a: assert property (sclSettled |-> $stable(sdaOe))
    else $error("sda moved while scl high");
  sda_after_fall_a: assert property ($rose(sdaOe) |-> lowAgeQ < 4'h8)
    else $error("sda drive not after scl fall");
endmodule // tsr_register_set_asserts

bind tsr_register_set tsr_register_set_asserts chk (.clk(clk), .reset_n(reset_n),
  .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(addrSel),
  .alertOut(alertOut), .alertOe(alertOe), .convStart(convStart), .convAbort(convAbort),
  .convDone(convDone), .convResult(convResult));

//--- tsr_bus_master.sv
`timescale 1ns/1ns
`include "tsr_defines.vh"
// ======
// two-wire master, 80 ns scl period, scl idles high
module tsr_bus_master (
  input wire clk,
  input wire sdaLine,
  input wire [2:0] devAddr,
  output reg sclHigh,
  output reg sdaPull
);
  reg r;
  integer nackCnt;
  // both lines released at start
  initial begin
    sclHigh = 1'b1;
    sdaPull = 1'b0;
    nackCnt = 0;
  end
  task wt(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // data moves mid low phase so it is stable around the rise
  task bitx(input b, output rb);
    begin
      sdaPull = ~b;
      wt(3);
      sclHigh = 1'b1;
      wt(3);
      rb = sdaLine;
      wt(2);
      sclHigh = 1'b0;
      wt(2);
    end
  endtask
  task startCond;
    begin
      sdaPull = 1'b1;
      wt(5);
      sclHigh = 1'b0;
      wt(2);
    end
  endtask
  task stopCond;
    begin
      sdaPull = 1'b1;
      wt(3);
      sclHigh = 1'b1;
      wt(3);
      sdaPull = 1'b0;
      wt(8);
    end
  endtask
  task byteOut(input [7:0] b);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bitx(b[i], r);
      bitx(1'b1, r);
      if (r !== 1'b0)
        nackCnt = nackCnt + 1;
    end
  endtask
  // pointer byte first, then n data bytes, upper first
  task wr(input [7:0] ptr, input [15:0] d, input integer n);
    begin
      startCond;
      byteOut({`TSR_ADDR_BASE, devAddr, 1'b0});
      byteOut(ptr);
      if (n > 0)
        byteOut(d[15:8]);
      if (n > 1)
        byteOut(d[7:0]);
      stopCond;
    end
  endtask
  // ack the upper byte, refuse the lower to end the read
  task rd(output [15:0] q);
    integer i;
    begin
      startCond;
      byteOut({`TSR_ADDR_BASE, devAddr, 1'b1});
      for (i = 15; i >= 0; i = i - 1) begin
        bitx(1'b1, r);
        q[i] = r;
        if (i == 8)
          bitx(1'b0, r);
      end
      bitx(1'b1, r);
      stopCond;
    end
  endtask
endmodule // tsr_bus_master

//--- tsr_register_set_tb.sv
`timescale 1ns/1ns
// ======
// bench top
module tsr_register_set_tb;
  reg clk;
  reg reset_n;
  reg convDone;
  reg [11:0] convResult;
  reg [2:0] addrSel;
  reg [15:0] q;
  reg [15:0] v;
  reg [7:0] p;
  wire sdaLine, sdaOe, sclHigh, sdaPull, alertOe, convStart, convAbort;
  integer seed, mismatches, compares, i, k, n, starts, busyM;
  // wired-and data line with pull-up
  assign sdaLine = ~(sdaPull | sdaOe);
  tsr_register_set dut (.clk(clk), .reset_n(reset_n), .sclIn(sclHigh), .sdaIn(sdaLine),
    .sdaOut(), .sdaOe(sdaOe), .addrSel(addrSel), .alertOut(), .alertOe(alertOe),
    .convStart(convStart), .convAbort(convAbort), .convDone(convDone),
    .convResult(convResult));
  tsr_bus_master mst (.clk(clk), .sdaLine(sdaLine), .devAddr(addrSel),
    .sclHigh(sclHigh), .sdaPull(sdaPull));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // converter stand-in tracks busy spans
  always @(posedge clk) begin
    if (convStart === 1'b1) begin
      busyM = 1;
      starts = starts + 1;
    end
    if (convAbort === 1'b1)
      busyM = 0;
  end
  function [15:0] expReg(input [2:0] ptr, input [15:0] d);
    case (ptr)
      3'h1: expReg = d & 16'h3f00;
      3'h2, 3'h3: expReg = d & 16'hfff0;
      default: expReg = 16'h0000;
    endcase
  endfunction
  function integer depth(input [1:0] fq);
    depth = (fq == 2'h0) ? 1 : {fq, 1'b0};
  endfunction
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("ERROR %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task end_sim;
    begin
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // bounded wait for a start, then hand back one result
  task conv(input [11:0] r);
    begin
      n = 0;
      while (busyM == 0 && n < 400) begin
        @(negedge clk);
        n = n + 1;
      end
      if (busyM == 0) begin
        chk("conv start", 16'h1, 16'h0);
        end_sim;
      end
      convResult = r;
      convDone = 1'b1;
      @(negedge clk);
      convDone = 1'b0;
      busyM = 0;
      repeat (6) @(negedge clk);
    end
  endtask
  // ======
  // main sequence
  initial begin
    seed = 14104;
    mismatches = 0;
    compares = 0;
    starts = 0;
    busyM = 0;
    reset_n = 1'b0;
    convDone = 1'b0;
    convResult = 12'h000;
    addrSel = $random(seed);
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    for (i = 0; i < 5; i = i + 1) begin
      mst.wr(i[7:0], 16'h0000, 0);
      mst.rd(q);
      chk("reset", (i == 2) ? 16'h5000 : (i == 3) ? 16'h4b00 : 16'h0000, q);
    end
    // junk in the upper pointer bits must not matter
    for (i = 0; i < 16; i = i + 1) begin
      p = $random(seed);
      v = $random(seed);
      mst.wr(p, v, 2);
      mst.rd(q);
      chk("readback", expReg(p[2:0], v), q);
    end
    mst.wr(8'h02, 16'h1900, 2);
    mst.wr(8'h03, 16'h1400, 2);
    mst.wr(8'h01, 16'h0100, 2);
    mst.wr(8'h01, 16'h0000, 2);
    for (i = 0; i < 3; i = i + 1) begin
      v = $random(seed);
      conv(v[11:0]);
      mst.wr(8'h00, 16'h0000, 0);
      mst.rd(q);
      chk("temp", {v[11:0], 4'h0}, q);
    end
    // shutdown clears, then each queue depth, polarity bit taken from the low bit of the depth code
    for (i = 0; i < 4; i = i + 1) begin
      mst.wr(8'h01, 16'h0100, 2);
      repeat (4) @(negedge clk);
      chk("alert off", 16'h0, {15'h0, alertOe});
      mst.wr(8'h01, {3'h0, i[1:0], i[0], 10'h000}, 2);
      for (k = 1; k <= depth(i[1:0]); k = k + 1) begin
        conv(12'h1a0);
        chk("queue", {15'h0, i[0] ^ (k == depth(i[1:0]))}, {15'h0, alertOe});
      end
    end
    mst.wr(8'h01, 16'h0100, 2);
    mst.wr(8'h01, 16'h0200, 2);
    conv(12'h1a0);
    conv(12'h160);
    chk("int held", 16'h1, {15'h0, alertOe});
    mst.rd(q);
    repeat (4) @(negedge clk);
    chk("int read", 16'h0, {15'h0, alertOe});
    conv(12'h1a0);
    chk("int armed low", 16'h0, {15'h0, alertOe});
    conv(12'h100);
    chk("int low", 16'h1, {15'h0, alertOe});
    // one-shot idles until its register is written
    mst.wr(8'h01, 16'h2000, 2);
    conv(12'h150);
    k = starts;
    repeat (200) @(negedge clk);
    chk("os idle", k[15:0], starts[15:0]);
    mst.wr(8'h04, 16'h0000, 1);
    conv(12'h155);
    chk("os start", k[15:0] + 16'h1, starts[15:0]);
    mst.wr(8'h00, 16'h0000, 0);
    mst.rd(q);
    chk("os result", 16'h1550, q);
    mst.wr(8'h01, 16'h2100, 2);
    mst.wr(8'h04, 16'h0000, 1);
    repeat (100) @(negedge clk);
    chk("sd ignores os", k[15:0] + 16'h1, starts[15:0]);
    chk("nacks", 16'h0, mst.nackCnt[15:0]);
    end_sim;
  end
endmodule // tsr_register_set_tb
